// ---- hdl/channel_freq.sv ----
`timescale 1ns/1ps
`default_nettype none
module channel_freq (
  // Clock and reset
  input  wire logic                                mclk_i,
  input  wire logic                                rst_n_i,
  // Tuning setup
  input  wire logic [1:0]                          band_i,
  input  wire logic [1:0]                          spacing_i,
  input  wire logic [tuner_status_pkg::CHANNEL_SETTING_W-1:0] index_i,
  // Frequency in 10 kHz units
  output logic      [tuner_status_pkg::DATA_W-1:0] freq_o
);
  import tuner_status_pkg::*;

  logic [4:0]        step;
  logic [15:0]       base;
  logic [DATA_W-1:0] freq_reg;
  logic [DATA_W-1:0] freq_next;

  always_comb begin
    case (spacing_i)
      SPACE_200K: step = STEP_200K;
      SPACE_100K: step = STEP_100K;
      SPACE_50K:  step = STEP_50K;
      default:    step = 5'h00;
    endcase
    if (band_i == BAND_WIDE_JP || band_i == BAND_JP) begin
      base = BASE_76M;
    end else begin
      base = BASE_87M5;
    end
    freq_next = base + (16'(index_i) * 16'(step));
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      freq_reg <= 16'h0000;
    end else begin
      freq_reg <= freq_next;
    end
  end

  assign freq_o = freq_reg;

endmodule
`default_nettype wire

// ---- hdl/tuner_status_pkg.sv ----
package tuner_status_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int CHANNEL_SETTING_W = 10;
  localparam int IRQ_N  = 3;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [4:0] OFS_BOOT_CFG   = 5'h09;
  localparam logic [4:0] OFS_STATUS     = 5'h0A;
  localparam logic [4:0] OFS_CHANNEL    = 5'h0B;
  localparam logic [4:0] OFS_RSV_C      = 5'h0C;
  localparam logic [4:0] OFS_RSV_D      = 5'h0D;
  localparam logic [4:0] OFS_RSV_E      = 5'h0E;
  localparam logic [4:0] OFS_CONTROL    = 5'h10;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h11;
  localparam logic [4:0] OFS_IRQ_MASK   = 5'h12;
  localparam logic [4:0] OFS_FREQ       = 5'h13;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int STAT_COMPLETE_BIT = 14;
  localparam int STAT_FAIL_BIT     = 13;
  localparam int STAT_RAIL_BIT     = 12;
  localparam int STAT_STEREO_BIT   = 8;
  localparam int CTRL_SEEK_BIT     = 0;
  localparam int CTRL_TUNE_BIT     = 1;
  localparam int CTRL_WRAP_BIT     = 2;
  localparam int CTRL_BAND_LSB     = 4;
  localparam int CTRL_SPACE_LSB    = 6;
  localparam int CTRL_GENERAL_PIN_THREE_LSB    = 8;
  localparam int IRQ_COMPLETE_BIT  = 0;
  localparam int IRQ_FAIL_BIT      = 1;
  localparam int IRQ_RAIL_BIT      = 2;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [15:0] BOOT_CFG_RESET = 16'h0000;
  localparam logic [15:0] RSV_C_RESET    = 16'h0000;
  localparam logic [15:0] RSV_D_RESET    = 16'h0000;
  localparam logic [15:0] RSV_E_RESET    = 16'h0000;
  localparam logic [7:0]  SIGNAL_STRENGTH_MAX       = 8'h4B;
  localparam logic [1:0]  GENERAL_PIN_THREE_STEREO   = 2'h1;
  localparam logic [1:0]  BAND_WIDE_EU   = 2'h0;
  localparam logic [1:0]  BAND_WIDE_JP   = 2'h1;
  localparam logic [1:0]  BAND_JP        = 2'h2;
  localparam logic [1:0]  SPACE_200K     = 2'h0;
  localparam logic [1:0]  SPACE_100K     = 2'h1;
  localparam logic [1:0]  SPACE_50K      = 2'h2;

  // Frequencies in units of 10 kHz
  localparam logic [15:0] BASE_87M5      = 16'h222E;
  localparam logic [15:0] BASE_76M       = 16'h1DB0;
  localparam logic [4:0]  STEP_200K      = 5'h14;
  localparam logic [4:0]  STEP_100K      = 5'h0A;
  localparam logic [4:0]  STEP_50K       = 5'h05;

endpackage

// ---- hdl/tuner_status_readback_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module tuner_status_readback_regs (
  // Clock and reset
  input  wire logic                                mclk_i,
  input  wire logic                                rst_n_i,
  // Register port
  input  wire logic [tuner_status_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [tuner_status_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                                wr_i,
  input  wire logic                                rd_i,
  output logic      [tuner_status_pkg::DATA_W-1:0] rdata_o,
  // Tuner core events and state
  input  wire logic                                seek_done_i,
  input  wire logic                                tune_done_i,
  input  wire logic                                seek_fail_i,
  input  wire logic                                band_limit_i,
  input  wire logic                                afc_railed_i,
  input  wire logic                                afc_update_i,
  input  wire logic                                stereo_i,
  input  wire logic [7:0]                          signal_strength_i,
  input  wire logic [tuner_status_pkg::CHANNEL_SETTING_W-1:0] channel_i,
  input  wire logic                                channel_valid_i,
  // Tuner core controls
  output logic                                     seek_req_o,
  output logic                                     tune_req_o,
  output logic                                     seek_wrap_mode_o,
  output logic      [1:0]                          band_o,
  output logic      [1:0]                          spacing_o,
  output logic                                     softmute_o,
  // General pin three
  output logic                                     general_pin_three_o,
  output logic                                     general_pin_three_oe_o,
  // Interrupt
  output logic                                     irq_o
);
  import tuner_status_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [DATA_W-1:0] boot_cfg_reg,   boot_cfg_next;
  logic              seek_req_reg,   seek_req_next;
  logic              tune_req_reg,   tune_req_next;
  logic              wrap_reg,       wrap_next;
  logic [1:0]        band_reg,       band_next;
  logic [1:0]        space_reg,      space_next;
  logic [1:0]        general_pin_three_sel_reg,  general_pin_three_sel_next;
  logic              complete_reg,   complete_next;
  logic              fail_reg,       fail_next;
  logic              rail_reg,       rail_next;
  logic              stereo_reg,     stereo_next;
  logic [7:0]        signal_strength_reg,       signal_strength_next;
  logic [CHANNEL_SETTING_W-1:0] channel_setting_reg,       channel_setting_next;
  logic              pin3_reg,       pin3_next;
  logic              pin3_oe_reg,    pin3_oe_next;
  logic [IRQ_N-1:0]  irq_stat_reg,   irq_stat_next;
  logic [IRQ_N-1:0]  irq_mask_reg,   irq_mask_next;
  logic [IRQ_N-1:0]  irq_event;
  logic              irq_reg,        irq_next;
  logic [DATA_W-1:0] rdata_reg,      rdata_next;
  logic [DATA_W-1:0] freq;
  logic [DATA_W-1:0] status_word;
  logic              op_done;
  logic              seek_drop;
  logic              tune_drop;
  logic              seeking;

  // ****************************************************************
  // Frequency readback
  // ****************************************************************
  channel_freq u_channel_freq (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .band_i    (band_reg),
    .spacing_i (space_reg),
    .index_i   (channel_setting_reg),
    .freq_o    (freq)
  );

  // ****************************************************************
  // Control register
  // ****************************************************************
  always_comb begin
    seek_req_next  = seek_req_reg;
    tune_req_next  = tune_req_reg;
    wrap_next      = wrap_reg;
    band_next      = band_reg;
    space_next     = space_reg;
    general_pin_three_sel_next = general_pin_three_sel_reg;
    boot_cfg_next  = boot_cfg_reg;
    if (wr_i && addr_i == OFS_CONTROL) begin
      seek_req_next  = wdata_i[CTRL_SEEK_BIT];
      tune_req_next  = wdata_i[CTRL_TUNE_BIT];
      wrap_next      = wdata_i[CTRL_WRAP_BIT];
      band_next      = wdata_i[CTRL_BAND_LSB +: 2];
      space_next     = wdata_i[CTRL_SPACE_LSB +: 2];
      general_pin_three_sel_next = wdata_i[CTRL_GENERAL_PIN_THREE_LSB +: 2];
    end
    // Host keeps this word intact by read-modify-write
    if (wr_i && addr_i == OFS_BOOT_CFG) begin
      boot_cfg_next = wdata_i;
    end
    seek_drop = seek_req_reg && !seek_req_next;
    tune_drop = tune_req_reg && !tune_req_next;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seek_req_reg  <= 1'b0;
      tune_req_reg  <= 1'b0;
      wrap_reg      <= 1'b0;
      band_reg      <= BAND_WIDE_EU;
      space_reg     <= SPACE_200K;
      general_pin_three_sel_reg <= 2'h0;
      boot_cfg_reg  <= BOOT_CFG_RESET;
    end else begin
      seek_req_reg  <= seek_req_next;
      tune_req_reg  <= tune_req_next;
      wrap_reg      <= wrap_next;
      band_reg      <= band_next;
      space_reg     <= space_next;
      general_pin_three_sel_reg <= general_pin_three_sel_next;
      boot_cfg_reg  <= boot_cfg_next;
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  always_comb begin
    op_done       = seek_done_i || tune_done_i;
    seeking       = seek_req_reg && !complete_reg;
    complete_next = complete_reg;
    fail_next     = fail_reg;
    rail_next     = rail_reg;
    channel_setting_next     = channel_setting_reg;
    if (seek_drop || tune_drop) begin
      complete_next = 1'b0;
    end
    if (op_done) begin
      complete_next = 1'b1;
    end
    if (seek_drop) begin
      fail_next = 1'b0;
    end
    if (!wrap_reg && seek_done_i && seek_fail_i) begin
      fail_next = 1'b1;
    end
    if (wrap_reg && seeking && band_limit_i) begin
      fail_next = 1'b1;
    end
    if (op_done || afc_update_i) begin
      rail_next = afc_railed_i;
    end
    if ((seeking && channel_valid_i) || op_done) begin
      channel_setting_next = channel_i;
    end
    stereo_next = stereo_i;
    signal_strength_next = (signal_strength_i > SIGNAL_STRENGTH_MAX) ? SIGNAL_STRENGTH_MAX
                                                : signal_strength_i;
    pin3_oe_next = (general_pin_three_sel_next == GENERAL_PIN_THREE_STEREO);
    pin3_next    = pin3_oe_next && stereo_next;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      complete_reg <= 1'b0;
      fail_reg     <= 1'b0;
      rail_reg     <= 1'b0;
      channel_setting_reg     <= '0;
      stereo_reg   <= 1'b0;
      signal_strength_reg     <= 8'h00;
      pin3_reg     <= 1'b0;
      pin3_oe_reg  <= 1'b0;
    end else begin
      complete_reg <= complete_next;
      fail_reg     <= fail_next;
      rail_reg     <= rail_next;
      channel_setting_reg     <= channel_setting_next;
      stereo_reg   <= stereo_next;
      signal_strength_reg     <= signal_strength_next;
      pin3_reg     <= pin3_next;
      pin3_oe_reg  <= pin3_oe_next;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign irq_event[IRQ_COMPLETE_BIT] = complete_next && !complete_reg;
  assign irq_event[IRQ_FAIL_BIT]     = fail_next && !fail_reg;
  assign irq_event[IRQ_RAIL_BIT]     = rail_next != rail_reg;

  // Sticky bits, write one to clear; a new event beats the clear
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_N; gi++) begin : g_irq
      always_comb begin
        irq_stat_next[gi] = irq_stat_reg[gi];
        if (wr_i && addr_i == OFS_IRQ_STATUS && wdata_i[gi]) begin
          irq_stat_next[gi] = 1'b0;
        end
        if (irq_event[gi]) begin
          irq_stat_next[gi] = 1'b1;
        end
      end
    end
  endgenerate

  always_comb begin
    irq_mask_next = irq_mask_reg;
    if (wr_i && addr_i == OFS_IRQ_MASK) begin
      irq_mask_next = wdata_i[IRQ_N-1:0];
    end
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg      <= irq_next;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    status_word                    = 16'h0000;
    status_word[STAT_COMPLETE_BIT] = complete_reg;
    status_word[STAT_FAIL_BIT]     = fail_reg;
    status_word[STAT_RAIL_BIT]     = rail_reg;
    status_word[STAT_STEREO_BIT]   = stereo_reg;
    status_word[7:0]               = signal_strength_reg;
    rdata_next                     = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        OFS_BOOT_CFG:   rdata_next = boot_cfg_reg;
        OFS_STATUS:     rdata_next = status_word;
        OFS_CHANNEL:    rdata_next = {6'h00, channel_setting_reg};
        OFS_RSV_C:      rdata_next = RSV_C_RESET;
        OFS_RSV_D:      rdata_next = RSV_D_RESET;
        OFS_RSV_E:      rdata_next = RSV_E_RESET;
        OFS_CONTROL: begin
          rdata_next[CTRL_SEEK_BIT]         = seek_req_reg;
          rdata_next[CTRL_TUNE_BIT]         = tune_req_reg;
          rdata_next[CTRL_WRAP_BIT]         = wrap_reg;
          rdata_next[CTRL_BAND_LSB +: 2]    = band_reg;
          rdata_next[CTRL_SPACE_LSB +: 2]   = space_reg;
          rdata_next[CTRL_GENERAL_PIN_THREE_LSB +: 2]   = general_pin_three_sel_reg;
        end
        OFS_IRQ_STATUS: rdata_next = {13'h0000, irq_stat_reg};
        OFS_IRQ_MASK:   rdata_next = {13'h0000, irq_mask_reg};
        OFS_FREQ:       rdata_next = freq;
        default:        rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata_o                = rdata_reg;
  assign seek_req_o             = seek_req_reg;
  assign tune_req_o             = tune_req_reg;
  assign seek_wrap_mode_o       = wrap_reg;
  assign band_o                 = band_reg;
  assign spacing_o              = space_reg;
  assign softmute_o             = rail_reg;
  assign general_pin_three_o    = pin3_reg;
  assign general_pin_three_oe_o = pin3_oe_reg;
  assign irq_o                  = irq_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_seek_drop;
    seek_drop;
  endsequence

  sequence s_quiet;
    !op_done && !band_limit_i;
  endsequence

  AST_COMPLETE_SET: assert property (
    op_done |=> complete_reg && status_word[STAT_COMPLETE_BIT])
    else $error("completion flag not set after done");

  AST_COMPLETE_CLR: assert property (
    (seek_drop || tune_drop) && !op_done |=> !complete_reg ##1
    (!complete_reg || $past(op_done)))
    else $error("completion flag not cleared by request drop");

  AST_FAIL_NOWRAP: assert property (
    !wrap_reg && seek_done_i && seek_fail_i |=> fail_reg)
    else $error("seek failure not flagged");

  AST_FAIL_WRAP: assert property (
    wrap_reg && seeking && band_limit_i |=> fail_reg)
    else $error("band limit not flagged");

  AST_FAIL_HOLD: assert property (
    fail_reg && seek_req_reg ##1 seek_req_reg |-> fail_reg)
    else $error("failure flag cleared without seek drop");

  AST_FAIL_DROP: assert property (
    s_seek_drop and s_quiet |=> !fail_reg)
    else $error("failure flag survived seek drop");

  AST_SOFTMUTE: assert property (
    op_done || afc_update_i |=> softmute_o == $past(afc_railed_i))
    else $error("softmute does not follow rail bit");

  AST_RAIL_UPD: assert property (
    afc_update_i |=> rail_reg == $past(afc_railed_i))
    else $error("rail bit not refreshed");

  AST_STEREO_PIN: assert property (
    general_pin_three_sel_reg == GENERAL_PIN_THREE_STEREO |-> general_pin_three_oe_o &&
    general_pin_three_o == stereo_reg)
    else $error("pin three does not mirror stereo");

  AST_SIGNAL_STRENGTH_MAX: assert property (
    signal_strength_reg <= SIGNAL_STRENGTH_MAX)
    else $error("signal strength above cap");

  AST_RSV_ZERO: assert property (
    rd_i && (addr_i == OFS_STATUS || addr_i == OFS_CHANNEL) |=>
    ($past(addr_i) == OFS_STATUS && !rdata_o[15] && rdata_o[11:9] == 3'h0)
    || ($past(addr_i) == OFS_CHANNEL && rdata_o[15:10] == 6'h00))
    else $error("reserved bits read nonzero");

  AST_RSV_WORDS: assert property (
    rd_i && (addr_i == OFS_RSV_C || addr_i == OFS_RSV_E) |=>
    rdata_o == 16'h0000)
    else $error("reserved word not zero");

  AST_READ_NOALTER: assert property (
    rd_i && !wr_i && !op_done && !band_limit_i |=>
    $stable(complete_reg) && $stable(fail_reg))
    else $error("status read altered a flag");

  AST_RDATA_ONE: assert property (
    !rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside its cycle");

endmodule
`default_nettype wire

// ---- verification/test_tuner_status_readback_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_tuner_status_readback_regs;
  import tuner_status_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [4:0]  addr_i = 5'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        afc_railed_i = 1'b0;
  logic        afc_update_i = 1'b0;
  logic        stereo_i = 1'b0;
  logic [7:0]  signal_strength_i = 8'h00;
  logic        fail_cmd = 1'b0;
  logic [9:0]  start_channel_setting = 10'h000;
  logic [15:0] rdata_o;
  logic        seek_done_i, tune_done_i, seek_fail_i, band_limit_i;
  logic [9:0]  channel_i;
  logic        channel_valid_i, seek_req_o, tune_req_o;
  logic        seek_wrap_mode_o, softmute_o, irq_o;
  logic [1:0]  band_o, spacing_o;
  logic        general_pin_three_o, general_pin_three_oe_o;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [15:0] rv;

  always #10 mclk_i = ~mclk_i;

  tuner_status_readback_regs dut (
    .mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .seek_done_i, .tune_done_i, .seek_fail_i, .band_limit_i,
    .afc_railed_i, .afc_update_i, .stereo_i, .signal_strength_i,
    .channel_i, .channel_valid_i, .seek_req_o, .tune_req_o,
    .seek_wrap_mode_o, .band_o, .spacing_o, .softmute_o,
    .general_pin_three_o, .general_pin_three_oe_o, .irq_o);

  tuner_core_model core (
    .mclk_i, .rst_n_i, .seek_req_i(seek_req_o), .tune_req_i(tune_req_o),
    .seek_wrap_mode_i(seek_wrap_mode_o), .fail_cmd_i(fail_cmd),
    .start_channel_setting_i(start_channel_setting), .seek_done_o(seek_done_i),
    .tune_done_o(tune_done_i), .seek_fail_o(seek_fail_i),
    .band_limit_o(band_limit_i), .channel_o(channel_i),
    .channel_valid_o(channel_valid_i));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  function automatic logic [15:0] ctl(input logic s, t, w,
                                     input logic [1:0] b, sp, sel);
    return {6'h00, sel, sp, b, 1'b0, w, t, s};
  endfunction

  task automatic wait_done();
    rv = 16'h0000;
    for (int i = 0; i < 20 && rv[14] !== 1'b1; i++) begin
      rd(OFS_STATUS, rv);
    end
  endtask

  task automatic t_regs();
    rd(OFS_BOOT_CFG, rv);
    check(rv, 16'h0000);
    wr(OFS_BOOT_CFG, rv);
    wr(OFS_RSV_C, 16'hFFFF);
    wr(OFS_RSV_E, 16'hFFFF);
    wr(OFS_STATUS, 16'hFFFF);
    rd(OFS_RSV_C, rv);
    check(rv, 16'h0000);
    rd(OFS_RSV_E, rv);
    check(rv, 16'h0000);
    rd(OFS_STATUS, rv);
    check(rv, 16'h0000);
    rd(5'h1F, rv);
    check(rv, 16'h0000);
    $display("register test done");
  endtask

  task automatic t_tune();
    logic [15:0] f;
    start_channel_setting <= 10'h3FF;
    wr(OFS_IRQ_MASK, 16'h0001);
    wr(OFS_CONTROL, ctl(1'b0, 1'b1, 1'b0, 2'h0, 2'h0, 2'h0));
    wait_done();
    check(rv & 16'hE000, 16'h4000);
    rd(OFS_STATUS, rv);
    check(rv & 16'h4000, 16'h4000);
    rd(OFS_CHANNEL, rv);
    check(rv, 16'h03FF);
    check({15'h0000, tune_req_o}, 16'h0001);
    @(negedge mclk_i);
    check(16'(irq_o), 16'h0001);
    wr(OFS_IRQ_MASK, 16'h0000);
    @(negedge mclk_i);
    check(16'(irq_o), 16'h0000);
    wr(OFS_IRQ_MASK, 16'h0001);
    wr(OFS_IRQ_STATUS, 16'h0001);
    @(negedge mclk_i);
    check(16'(irq_o), 16'h0000);
    for (int b = 0; b < 4; b++) begin
      for (int s = 0; s < 4; s++) begin
        wr(OFS_CONTROL, ctl(1'b0, 1'b1, 1'b0, 2'(b), 2'(s), 2'h0));
        rd(OFS_FREQ, rv);
        f = (b == 1 || b == 2) ? 16'h1DB0 : 16'h222E;
        f = f + 16'h03FF * ((s == 0) ? 16'h0014 :
                            (s == 1) ? 16'h000A :
                            (s == 2) ? 16'h0005 : 16'h0000);
        check(rv, f);
        check({12'h000, band_o, spacing_o}, {12'h000, 2'(b), 2'(s)});
      end
    end
    wr(OFS_CONTROL, 16'h0000);
    rd(OFS_STATUS, rv);
    check(rv & 16'h4000, 16'h0000);
    $display("tune test done");
  endtask

  task automatic t_seek(input logic w, input logic fl);
    fail_cmd <= fl;
    start_channel_setting <= 10'h010;
    wr(OFS_CONTROL, ctl(1'b1, 1'b0, w, 2'h0, 2'h0, 2'h0));
    wait_done();
    check(rv & 16'h6000, fl ? 16'h6000 : 16'h4000);
    check({13'h0000, seek_wrap_mode_o, tune_req_o, seek_req_o},
          {13'h0000, w, 2'h1});
    rd(OFS_STATUS, rv);
    check(rv & 16'h6000, fl ? 16'h6000 : 16'h4000);
    rd(OFS_CHANNEL, rv);
    check(rv, 16'h0014);
    wr(OFS_CONTROL, ctl(1'b0, 1'b0, w, 2'h0, 2'h0, 2'h0));
    rd(OFS_STATUS, rv);
    check(rv & 16'h6000, 16'h0000);
    $display("seek test done");
  endtask

  task automatic t_misc();
    @(posedge mclk_i);
    afc_railed_i <= 1'b1;
    stereo_i <= 1'b1;
    signal_strength_i <= 8'hC8;
    wr(OFS_CONTROL, ctl(1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 2'h1));
    afc_update_i <= 1'b1;
    @(posedge mclk_i);
    afc_update_i <= 1'b0;
    rd(OFS_STATUS, rv);
    check(rv, 16'h114B);
    @(negedge mclk_i);
    check(16'(softmute_o), 16'h0001);
    check({14'h0, general_pin_three_o, general_pin_three_oe_o}, 16'h0003);
    @(posedge mclk_i);
    afc_railed_i <= 1'b0;
    stereo_i <= 1'b0;
    signal_strength_i <= 8'h20;
    afc_update_i <= 1'b1;
    @(posedge mclk_i);
    afc_update_i <= 1'b0;
    rd(OFS_STATUS, rv);
    check(rv, 16'h0020);
    @(negedge mclk_i);
    check({14'h0, general_pin_three_o, softmute_o}, 16'h0000);
    rd(OFS_IRQ_STATUS, rv);
    check(rv, 16'h0007);
    check(16'(irq_o), 16'h0001);
    $display("status test done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_tune();
    t_seek(1'b0, 1'b0);
    t_seek(1'b0, 1'b1);
    t_seek(1'b1, 1'b1);
    t_misc();
    final_report();
  end

  // Cut a hang short
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      final_report();
    end
  end
endmodule
`default_nettype wire

// ---- verification/tuner_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tuner_core_model (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // Requests from the block
  input  wire logic       seek_req_i,
  input  wire logic       tune_req_i,
  input  wire logic       seek_wrap_mode_i,
  // Bench commands
  input  wire logic       fail_cmd_i,
  input  wire logic [9:0] start_channel_setting_i,
  // Events to the block
  output logic            seek_done_o,
  output logic            tune_done_o,
  output logic            seek_fail_o,
  output logic            band_limit_o,
  output logic [9:0]      channel_o,
  output logic            channel_valid_o
);
  logic [3:0] cnt_reg;
  logic       seek_q;
  logic       tune_q;

  // Each operation runs five cycles after its request rises
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg   <= 4'h0;
      seek_q    <= 1'b0;
      tune_q    <= 1'b0;
      channel_o <= 10'h000;
    end else begin
      seek_q <= seek_req_i;
      tune_q <= tune_req_i;
      if ((seek_req_i && !seek_q) || (tune_req_i && !tune_q)) begin
        cnt_reg   <= 4'h5;
        channel_o <= start_channel_setting_i;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
        if (seek_req_i && cnt_reg > 4'h1) begin
          channel_o <= channel_o + 10'h001;
        end
      end
    end
  end

  assign channel_valid_o = seek_req_i && cnt_reg > 4'h1;
  assign band_limit_o = seek_req_i && seek_wrap_mode_i && fail_cmd_i
                        && cnt_reg == 4'h2;
  assign seek_done_o = seek_req_i && cnt_reg == 4'h1;
  assign tune_done_o = tune_req_i && !seek_req_i && cnt_reg == 4'h1;
  assign seek_fail_o = seek_done_o && fail_cmd_i && !seek_wrap_mode_i;
endmodule
`default_nettype wire
